// file: core/smcg_pkg.sv
// Shared constants and types for the sleep mode clock gating block
package smcg_pkg;

  // Mode-select field codes; codes 3'h4 and 3'h5 are reserved
  localparam logic [2:0] MODE_IDLE    = 3'h0;
  localparam logic [2:0] MODE_ADC_NR  = 3'h1;
  localparam logic [2:0] MODE_PDOWN   = 3'h2;
  localparam logic [2:0] MODE_PSAVE   = 3'h3;
  localparam logic [2:0] MODE_STANDBY = 3'h6;
  localparam logic [2:0] MODE_EXT_SBY = 3'h7;
  localparam logic [2:0] MODE_RESET   = 3'h0;

  // Port geometry
  localparam int PORT_NUM   = 4;
  localparam int PORT_WIDTH = 8;

  // Least low time on the external reset pin, and its cycle count at 10 MHz
  localparam int CLK_PERIOD_NS = 100;
  localparam int RST_MIN_NS    = 500;
  localparam int RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_SLEEP,
    ST_WAKE
  } smcg_state_e;

  // One enable per clock domain the block gates
  typedef struct packed {
    logic cpu;
    logic mem;
    logic timer;
    logic spi;
    logic io;
    logic adc;
    logic irq;
    logic async_tmr;
    logic osc;
  } smcg_clk_s;

  localparam smcg_clk_s CLK_ALL_ON = 9'h1ff;

  // Core-side control of one 8-bit port
  typedef struct packed {
    logic [PORT_WIDTH-1:0] dir;
    logic [PORT_WIDTH-1:0] out;
    logic [PORT_WIDTH-1:0] pull;
  } smcg_port_s;

  // Wake sources seen by the sequencer
  typedef struct packed {
    logic ext_irq;
    logic async_tmr;
    logic adc;
    logic periph;
  } smcg_wake_s;

endpackage : smcg_pkg

// file: core/smcg_rst_filt.sv
// External reset pin synchroniser and minimum pulse length filter
`timescale 1ns/1ps
`default_nettype none
module smcg_rst_filt
  import smcg_pkg::*;
#(
  parameter int MIN_CYC = RST_MIN_CYC
) (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_reset,
  // Pin
  input  wire logic i_ext_reset_n,
  // Filtered reset
  output logic      o_ext_reset
);

  logic       meta_r;
  logic       sync_r;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       rst_r;
  logic       rst_nxt;

  // Low time is counted; a glitch shorter than MIN_CYC never resets
  always_comb begin
    cnt_nxt = cnt_r;
    rst_nxt = rst_r;
    if (sync_r) begin
      cnt_nxt = 8'h00;
      rst_nxt = 1'b0;
    end else if (cnt_r == 8'(MIN_CYC - 1)) begin
      rst_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end

  // Two flops ahead of the counter; pin idles high so resets to high
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      cnt_r  <= 8'h00;
      rst_r  <= 1'b0;
    end else begin
      meta_r <= i_ext_reset_n;
      sync_r <= meta_r;
      cnt_r  <= cnt_nxt;
      rst_r  <= rst_nxt;
    end
  end

  assign o_ext_reset = rst_r;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  chk_rst_after_low: assert property ((!sync_r && cnt_r == 8'(MIN_CYC - 1)) |=> rst_r)
    else $error("reset not raised after minimum low time");
  chk_short_pulse: assert property ($rose(rst_r) |-> !$past(sync_r, 1) && !$past(sync_r, 2))
    else $error("reset raised by short pulse");

endmodule : smcg_rst_filt
`default_nettype wire

// file: core/smcg_top.sv
// Sleep mode sequencer, clock gating and port reset control
`timescale 1ns/1ps
`default_nettype none
module smcg_top
  import smcg_pkg::*;
#(
  parameter int MIN_CYC = RST_MIN_CYC
) (
  // Clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_reset,
  input  wire logic                  i_ext_reset_n,
  // Sleep control from core
  input  wire logic                  i_sleep_req,
  input  wire logic                  i_sleep_en,
  input  wire logic [2:0]            i_mode_sel,
  input  wire smcg_wake_s            i_wake,
  // Clock enables and status
  output smcg_clk_s                  o_clk_en,
  output logic                       o_core_resume,
  output logic                       o_sleeping,
  output logic                       o_sys_reset,
  // Port control from core
  input  wire smcg_port_s [3:0]      i_port_ctl,
  // Port pins
  input  wire logic [PORT_WIDTH-1:0] i_first_port_pins,
  input  wire logic [PORT_WIDTH-1:0] i_second_port_pins,
  input  wire logic [PORT_WIDTH-1:0] i_third_port_pins,
  input  wire logic [PORT_WIDTH-1:0] i_fourth_port_pins,
  output logic [PORT_WIDTH-1:0]      o_first_port_pins,
  output logic [PORT_WIDTH-1:0]      o_second_port_pins,
  output logic [PORT_WIDTH-1:0]      o_third_port_pins,
  output logic [PORT_WIDTH-1:0]      o_fourth_port_pins,
  output logic [PORT_WIDTH-1:0]      o_first_port_pins_oe_n,
  output logic [PORT_WIDTH-1:0]      o_second_port_pins_oe_n,
  output logic [PORT_WIDTH-1:0]      o_third_port_pins_oe_n,
  output logic [PORT_WIDTH-1:0]      o_fourth_port_pins_oe_n,
  output logic [3:0][PORT_WIDTH-1:0] o_pullup_en,
  output logic [3:0][PORT_WIDTH-1:0] o_port_in
);

  // Clock enables for each mode
  function automatic smcg_clk_s mode_gates(input logic [2:0] mode);
    smcg_clk_s g;
    g = '0;
    case (mode)
      MODE_IDLE: begin
        g = CLK_ALL_ON;
        g.cpu = 1'b0;
      end
      MODE_ADC_NR: begin
        g.adc       = 1'b1;
        g.async_tmr = 1'b1;
        g.irq       = 1'b1;
        g.osc       = 1'b1;
      end
      MODE_PDOWN: g = '0;
      MODE_PSAVE: g.async_tmr = 1'b1;
      MODE_STANDBY: g.osc = 1'b1;
      MODE_EXT_SBY: begin
        g.osc       = 1'b1;
        g.async_tmr = 1'b1;
      end
      default: g = CLK_ALL_ON;
    endcase
    return g;
  endfunction : mode_gates

  // Which sources may end each mode; external interrupt ends all of them
  function automatic logic wake_ok(input logic [2:0] mode, input smcg_wake_s w);
    logic ok;
    ok = w.ext_irq;
    case (mode)
      MODE_IDLE:    ok = ok | w.periph | w.async_tmr | w.adc;
      MODE_ADC_NR:  ok = ok | w.async_tmr | w.adc;
      MODE_PSAVE:   ok = ok | w.async_tmr;
      MODE_EXT_SBY: ok = ok | w.async_tmr;
      default:      ok = ok;
    endcase
    return ok;
  endfunction : wake_ok

  // Reserved codes never put the device to sleep
  function automatic logic mode_valid(input logic [2:0] mode);
    return (mode != 3'h4) && (mode != 3'h5);
  endfunction : mode_valid

  logic        ext_rst;
  logic        rst_any;
  smcg_state_e state_r;
  smcg_state_e state_nxt;
  logic [2:0]  mode_r;
  logic [2:0]  mode_nxt;
  smcg_clk_s   clk_r;
  smcg_clk_s   clk_nxt;
  logic [3:0][PORT_WIDTH-1:0] out_r;
  logic [3:0][PORT_WIDTH-1:0] meta_r;
  logic [3:0][PORT_WIDTH-1:0] sync_r;
  logic [3:0][PORT_WIDTH-1:0] pins_in;
  logic [3:0][PORT_WIDTH-1:0] oe_n;

  smcg_rst_filt #(.MIN_CYC(MIN_CYC)) u_rst_filt (
    .i_core_clk    (i_core_clk),
    .i_reset       (i_reset),
    .i_ext_reset_n (i_ext_reset_n),
    .o_ext_reset   (ext_rst)
  );

  // Power-on reset acts without a clock; pin reset once filtered
  assign rst_any     = i_reset | ext_rst;
  assign o_sys_reset = rst_any;

  // Sleep sequencer: mode is latched on entry so later field writes cannot alter it
  always_comb begin
    state_nxt = state_r;
    mode_nxt  = mode_r;
    clk_nxt   = clk_r;
    if (ext_rst) begin
      state_nxt = ST_ACTIVE;
      clk_nxt   = CLK_ALL_ON;
    end else begin
      case (state_r)
        ST_ACTIVE: begin
          if (i_sleep_req && i_sleep_en && mode_valid(i_mode_sel)) begin
            state_nxt = ST_SLEEP;
            mode_nxt  = i_mode_sel;
            clk_nxt   = mode_gates(i_mode_sel);
          end
        end
        ST_SLEEP: begin
          if (wake_ok(mode_r, i_wake)) begin
            state_nxt = ST_WAKE;
            clk_nxt   = CLK_ALL_ON;
          end
        end
        ST_WAKE: state_nxt = ST_ACTIVE;
        default: begin
          state_nxt = ST_ACTIVE;
          clk_nxt   = CLK_ALL_ON;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= ST_ACTIVE;
      mode_r  <= MODE_RESET;
      clk_r   <= CLK_ALL_ON;
    end else begin
      state_r <= state_nxt;
      mode_r  <= mode_nxt;
      clk_r   <= clk_nxt;
    end
  end

  assign o_clk_en      = clk_r;
  assign o_sleeping    = (state_r == ST_SLEEP);
  assign o_core_resume = (state_r == ST_WAKE);

  // Pin inputs pass two flops; output data is registered
  assign pins_in = {i_fourth_port_pins, i_third_port_pins, i_second_port_pins, i_first_port_pins};

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_r <= '0;
      sync_r <= '0;
      out_r  <= '0;
    end else begin
      meta_r <= pins_in;
      sync_r <= meta_r;
      for (int p = 0; p < PORT_NUM; p++) begin
        out_r[p] <= i_port_ctl[p].out;
      end
    end
  end

  // Enables and pull-ups are gated by the reset level itself, so pins float on power-on reset without a clock
  always_comb begin
    for (int p = 0; p < PORT_NUM; p++) begin
      oe_n[p]        = ~(i_port_ctl[p].dir & {PORT_WIDTH{~rst_any}});
      o_pullup_en[p] = i_port_ctl[p].pull & ~i_port_ctl[p].dir & {PORT_WIDTH{~rst_any}};
    end
  end

  assign o_port_in               = sync_r;
  assign o_first_port_pins       = out_r[0];
  assign o_second_port_pins      = out_r[1];
  assign o_third_port_pins       = out_r[2];
  assign o_fourth_port_pins      = out_r[3];
  assign o_first_port_pins_oe_n  = oe_n[0];
  assign o_second_port_pins_oe_n = oe_n[1];
  assign o_third_port_pins_oe_n  = oe_n[2];
  assign o_fourth_port_pins_oe_n = oe_n[3];

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  sequence s_enter(logic [2:0] m);
    state_r == ST_ACTIVE && !ext_rst && i_sleep_req && i_sleep_en && i_mode_sel == m;
  endsequence
  sequence s_resume;
    o_clk_en == CLK_ALL_ON && o_core_resume ##1 state_r == ST_ACTIVE && o_clk_en.cpu;
  endsequence

  chk_idle_gates: assert property (s_enter(MODE_IDLE) |=> o_sleeping && !o_clk_en.cpu && o_clk_en.mem
    && o_clk_en.timer && o_clk_en.spi && o_clk_en.irq) else $error("idle gating wrong");
  chk_pdown_gates: assert property (o_sleeping && mode_r == MODE_PDOWN |-> o_clk_en == '0)
    else $error("power-down left a clock running");
  chk_psave_timer: assert property (s_enter(MODE_PSAVE) |=> o_clk_en.async_tmr && !o_clk_en.osc
    && !o_clk_en.cpu) else $error("power-save timer gating wrong");
  chk_adcnr_gates: assert property (s_enter(MODE_ADC_NR) |=> o_clk_en.adc && o_clk_en.async_tmr
    && !o_clk_en.cpu && !o_clk_en.io && !o_clk_en.spi) else $error("noise reduction gating wrong");
  chk_standby_osc: assert property (s_enter(MODE_STANDBY) |=> o_clk_en.osc && !o_clk_en.async_tmr)
    else $error("standby oscillator gating wrong");
  chk_extsby_osc: assert property (s_enter(MODE_EXT_SBY) |=> o_clk_en.osc && o_clk_en.async_tmr)
    else $error("extended standby gating wrong");
  chk_reset_tristate: assert property (rst_any |-> (&oe_n) && o_pullup_en == '0)
    else $error("pin driven during reset");
  chk_pullup_bit: assert property (!rst_any |-> o_pullup_en[0] == (i_port_ctl[0].pull & ~i_port_ctl[0].dir))
    else $error("pull-up enable wrong");
  chk_wake_restore: assert property (o_sleeping && !ext_rst && wake_ok(mode_r, i_wake) |=> s_resume)
    else $error("clocks not restored before resume");
  chk_sleep_gate: assert property (state_r == ST_ACTIVE && !i_sleep_en |=> !o_sleeping)
    else $error("sleep entered without enable");

endmodule : smcg_top
`default_nettype wire

// file: tb/smcg_pad_model.sv
// Pad model for the four ports: resolves pin levels from drive, pull-up and float
`timescale 1ns/1ps
`default_nettype none
module smcg_pad_model
  import smcg_pkg::*;
(
  // Clock
  input  wire logic                       i_core_clk,
  // Pad controls from the block
  input  wire logic [3:0][PORT_WIDTH-1:0] i_out,
  input  wire logic [3:0][PORT_WIDTH-1:0] i_oe_n,
  input  wire logic [3:0][PORT_WIDTH-1:0] i_pull,
  // Resolved pin levels
  output logic      [3:0][PORT_WIDTH-1:0] o_pin
);
  logic float_r = 1'b0;

  // A floating pin toggles so a stale level never passes for a real one
  always_ff @(posedge i_core_clk) begin
    float_r <= ~float_r;
  end

  // Drive wins only while enabled, then the pull-up, then the float pattern
  assign o_pin = (~i_oe_n & i_out) | (i_oe_n & (i_pull | {PORT_NUM*PORT_WIDTH{float_r}}));
endmodule : smcg_pad_model
`default_nettype wire

// file: tb/test_sleep_mode_clock_gating.sv
// Self-checking bench for the sleep mode clock gating block
`timescale 1ns/1ps
`default_nettype none
module test_sleep_mode_clock_gating
  import smcg_pkg::*;
;
  localparam int MIN_C = 2;
  logic                       core_clk    = 1'b0;
  logic                       reset       = 1'b1;
  logic                       ext_reset_n = 1'b1;
  logic                       sleep_req   = 1'b0;
  logic                       sleep_en    = 1'b0;
  logic [2:0]                 mode_sel    = MODE_IDLE;
  smcg_wake_s                 wake        = '0;
  smcg_port_s [3:0]           port_ctl    = '0;
  smcg_clk_s                  clk_en;
  logic                       core_resume;
  logic                       sleeping;
  logic                       sys_reset;
  logic [3:0][PORT_WIDTH-1:0] pin_out;
  logic [3:0][PORT_WIDTH-1:0] oe_n;
  logic [3:0][PORT_WIDTH-1:0] pull_en;
  logic [3:0][PORT_WIDTH-1:0] port_in;
  logic [3:0][PORT_WIDTH-1:0] pin_lvl;
  int                         fails   = 0;
  int                         n_tests = 0;

  // 10 MHz clock
  always #50 core_clk = ~core_clk;

  smcg_top #(.MIN_CYC(MIN_C)) DUT (
    .i_core_clk(core_clk), .i_reset(reset), .i_ext_reset_n(ext_reset_n),
    .i_sleep_req(sleep_req), .i_sleep_en(sleep_en), .i_mode_sel(mode_sel), .i_wake(wake),
    .o_clk_en(clk_en), .o_core_resume(core_resume), .o_sleeping(sleeping), .o_sys_reset(sys_reset),
    .i_port_ctl(port_ctl),
    .i_first_port_pins(pin_lvl[0]), .i_second_port_pins(pin_lvl[1]),
    .i_third_port_pins(pin_lvl[2]), .i_fourth_port_pins(pin_lvl[3]),
    .o_first_port_pins(pin_out[0]), .o_second_port_pins(pin_out[1]),
    .o_third_port_pins(pin_out[2]), .o_fourth_port_pins(pin_out[3]),
    .o_first_port_pins_oe_n(oe_n[0]), .o_second_port_pins_oe_n(oe_n[1]),
    .o_third_port_pins_oe_n(oe_n[2]), .o_fourth_port_pins_oe_n(oe_n[3]),
    .o_pullup_en(pull_en), .o_port_in(port_in));

  smcg_pad_model u_pads (.i_core_clk(core_clk), .i_out(pin_out), .i_oe_n(oe_n), .i_pull(pull_en), .o_pin(pin_lvl));

  // Compare and count
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] want);
    n_tests++;
    if (seen !== want) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, want, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // Bounded wait for sleeping (0), resume (1) or system reset (2)
  task automatic wait_hi(input int sel);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8 && !hit; i++) begin
      @(negedge core_clk);
      hit = (sel == 0) ? (sleeping === 1'b1) : (sel == 1) ? (core_resume === 1'b1) : (sys_reset === 1'b1);
    end
    if (!hit) begin
      fails++;
      $display("unexpected timeout waiting on output %0d", sel);
      complete_run();
    end
  endtask : wait_hi

  // One-cycle sleep request pulse, as the core issues it
  task automatic enter(input logic [2:0] m, input logic en);
    @(posedge core_clk);
    sleep_req <= 1'b1;
    sleep_en  <= en;
    mode_sel  <= m;
    @(posedge core_clk);
    sleep_req <= 1'b0;
  endtask : enter

  // Reserved codes and a cleared enable must leave the block awake
  task automatic t_refused;
    logic [2:0] m [3] = '{3'h4, 3'h5, MODE_IDLE};
    for (int i = 0; i < 3; i++) begin
      enter(m[i], i < 2);
      repeat (3) @(negedge core_clk);
      check("sleeping", sleeping, 1'b0);
      check("clk_en", clk_en, CLK_ALL_ON);
    end
    $display("refused requests done");
  endtask : t_refused

  // Every mode: gating, a wake source it must ignore (none for idle), then a wake it must take
  task automatic t_modes;
    logic [2:0] md [6]   = '{MODE_IDLE, MODE_ADC_NR, MODE_PDOWN, MODE_PSAVE, MODE_STANDBY, MODE_EXT_SBY};
    logic [8:0] msk [6]  = '{9'h1e4, 9'h17a, 9'h1ff, 9'h102, 9'h101, 9'h103};
    logic [8:0] want [6] = '{9'h0e4, 9'h00a, 9'h000, 9'h002, 9'h001, 9'h003};
    logic [3:0] bad [6]  = '{4'h0, 4'h1, 4'h4, 4'h2, 4'h1, 4'h2};
    logic [3:0] good [6] = '{4'h1, 4'h2, 4'h8, 4'h4, 4'h8, 4'h4};
    for (int i = 0; i < 6; i++) begin
      enter(md[i], 1'b1);
      wait_hi(0);
      check("clk_en gated", clk_en & msk[i], want[i]);
      @(posedge core_clk);
      mode_sel <= MODE_IDLE;
      wake     <= bad[i];
      repeat (3) @(negedge core_clk);
      check("sleeping", sleeping, 1'b1);
      @(posedge core_clk);
      wake <= good[i];
      wait_hi(1);
      check("clk_en woken", clk_en, CLK_ALL_ON);
      check("sleeping", sleeping, 1'b0);
      @(posedge core_clk);
      wake <= '0;
      @(negedge core_clk);
      check("resume", core_resume, 1'b0);
    end
    $display("sleep modes done");
  endtask : t_modes

  // Per-bit direction and pull-up, then a power-on reset over driven pins
  task automatic t_ports;
    logic [7:0]       d;
    smcg_port_s [3:0] pc;
    for (int p = 0; p < PORT_NUM; p++)
      pc[p] = '{dir: 8'h0f + 8'(p), out: 8'ha5, pull: 8'h33};
    @(posedge core_clk);
    port_ctl <= pc;
    // Driven data passes the output register and two sync flops before port_in shows it
    repeat (4) @(negedge core_clk);
    for (int p = 0; p < PORT_NUM; p++) begin
      d = 8'h0f + 8'(p);
      check("oe_n", oe_n[p], d ^ 8'hff);
      check("pullup", pull_en[p], 8'h33 & ~d);
      check("pin out", pin_out[p], 8'ha5);
      check("port in", port_in[p] & (d | 8'h33), (8'ha5 & d) | (8'h33 & ~d));
    end
    @(posedge core_clk);
    reset <= 1'b1;
    @(negedge core_clk);
    check("oe_n", oe_n, 32'hffffffff);
    check("pullup", pull_en, 32'h00000000);
    check("sys_reset", sys_reset, 1'b1);
    @(posedge core_clk);
    reset <= 1'b0;
    $display("ports done");
  endtask : t_ports

  // Short pin pulse ignored; long pulse resets, wakes power-down, tri-states
  task automatic t_pin_reset;
    enter(MODE_PDOWN, 1'b1);
    wait_hi(0);
    @(posedge core_clk);
    ext_reset_n <= 1'b0;
    @(posedge core_clk);
    ext_reset_n <= 1'b1;
    repeat (MIN_C + 5) @(negedge core_clk);
    check("sys_reset short", sys_reset, 1'b0);
    check("sleeping", sleeping, 1'b1);
    @(posedge core_clk);
    ext_reset_n <= 1'b0;
    wait_hi(2);
    check("oe_n", oe_n, 32'hffffffff);
    check("pullup", pull_en, 32'h00000000);
    // The sequencer follows the filtered reset one edge after it rises
    @(negedge core_clk);
    check("sleeping", sleeping, 1'b0);
    check("clk_en", clk_en, CLK_ALL_ON);
    @(posedge core_clk);
    ext_reset_n <= 1'b1;
    repeat (4) @(negedge core_clk);
    check("sys_reset", sys_reset, 1'b0);
    $display("pin reset done");
  endtask : t_pin_reset

  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    t_refused();
    t_modes();
    t_ports();
    t_pin_reset();
    complete_run();
  end
endmodule : test_sleep_mode_clock_gating
`default_nettype wire
